// ===== shared/ahs_consts.svh
// constants of the axis homing sequencer: timing counts and reset values
`ifndef AHS_CONSTS_SVH
`define AHS_CONSTS_SVH
`define AHS_CLK_PERIOD_NS 10
`define AHS_POS_W 32
`define AHS_POS_RESET 32'h0000_0000
`define AHS_ENC_RESET 32'h0000_0000
// speed selections
`define AHS_SPEED_STOP 2'h0
`define AHS_SPEED_REF1 2'h1
`define AHS_SPEED_REF2 2'h2
// mode numbers of the controller's mode field
`define AHS_MODE_W 5
`define AHS_MODE_CALIB 5'h05
`define AHS_MODE_INC_ABS 5'h06
`define AHS_MODE_AUTO 5'h08
`define AHS_MODE_AUTO_SINGLE 5'h09
`define AHS_MODE_TEACH 5'h0a
`endif

// ===== shared/ahs_pkg.sv
// types of the axis homing sequencer
package ahs_pkg;
   // homing run phases
   typedef enum logic [2:0] {
      AHS_IDLE,
      AHS_AWAY,
      AHS_TOWARD,
      AHS_ARMED,
      AHS_BRAKE
   } ahs_state_t;
endpackage : ahs_pkg

// ===== hdl/ahs_sequencer.sv
// axis homing sequencer: homing run and set-reference calibration
`timescale 1ns/100ps
`include "ahs_consts.svh"
module ahs_sequencer #(
   parameter int POS_W = `AHS_POS_W, // coordinate width
   parameter bit ABS_ENC = 1'b0 // 1 for the absolute encoder variant
) (
   input wire logic ref_clk_i, // module clock
   input wire logic rstn_i, // power-up reset, active low
   input wire logic [`AHS_MODE_W-1:0] mode_i, // selected operating mode
   input wire logic start_i, // start pulse from the controller
   input wire logic stop_i, // abort pulse from the controller
   input wire logic set_only_i, // 1 set without movement, 0 homing run (set without movement too if ABS_ENC)
   input wire logic md_valid_i, // error-free machine data loaded
   input wire logic ref_dir_i, // approach direction, 1 forward
   input wire logic [POS_W-1:0] ref_coord_i, // reference coordinate
   input wire logic [POS_W-1:0] offset_i, // sum of zero and tool offsets
   input wire logic [POS_W-1:0] enc_pos_i, // encoder count, scaled to travel units
   input wire logic backlash_nz_i, // backlash compensation configured
   input wire logic move_done_i, // a traverse finished (same clock)
   input wire logic backup_ok_i, // battery backup present
   input wire logic module_removed_i, // module taken out
   input wire logic prox_precontact_i, // precontact pin, active high
   input wire logic zero_marker_i, // encoder zero pulse pin
   input wire logic limit_fwd_i, // forward hardware limit pin
   input wire logic limit_rev_i, // reverse hardware limit pin
   input wire logic drive_at_rest_i, // drive reports standstill
   output logic drive_en_o, // drive moving
   output logic drive_dir_o, // 1 forward
   output logic [1:0] speed_sel_o, // stop, ref speed 1 or 2
   output logic home_set_o, // reference/home point set
   output logic soft_limit_en_o, // evaluate software limits
   output logic mode_block_o, // requested mode refused
   output logic md_error_o, // start refused for missing data
   output logic backlash_skip_o, // suppress compensation on next traverse
   output logic [POS_W-1:0] actual_pos_o // actual value incl. offsets
);
   import ahs_pkg::*;

   // ------------------------------------------------------------
   // state record
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] pc_sync; // precontact synchroniser
      logic [2:0] zm_sync; // marker synchroniser
      logic [2:0] lf_sync; // forward limit synchroniser
      logic [2:0] lr_sync; // reverse limit synchroniser
      logic pc_lvl; // filtered precontact
      logic zm_lvl; // filtered marker
      logic lf_lvl; // filtered forward limit
      logic lr_lvl; // filtered reverse limit
      ahs_state_t phase; // homing phase
      logic seen_pc; // precontact met on away leg
      logic home; // home point valid
      logic [POS_W-1:0] bind_enc; // encoder reading bound to home
      logic [POS_W-1:0] bind_coord; // coordinate bound to it
      logic drv_en; // drive output
      logic drv_dir; // direction output
      logic [1:0] spd; // speed output
      logic blk; // mode refused
      logic mderr; // data error
      logic bl_skip; // backlash skip
      logic [POS_W-1:0] act; // actual value
   } ahs_regs_t;

   ahs_regs_t st_reg; // registered state
   ahs_regs_t st_next; // next state

   logic lim_away; // limit in the away direction
   logic pc_rise; // precontact rising edge
   logic pc_fall; // precontact falling edge
   logic zm_rise; // marker rising edge
   logic calib_start; // calibration start taken
   logic [POS_W-1:0] pos_now; // coordinate of current encoder reading

   // ------------------------------------------------------------
   // edge detection on agreeing stages two and three
   // ------------------------------------------------------------
   always_comb begin
      // a change counts only when stages two and three agree
      pc_rise = (st_reg.pc_sync[2:1] == 2'b11) && !st_reg.pc_lvl;
      pc_fall = (st_reg.pc_sync[2:1] == 2'b00) && st_reg.pc_lvl;
      zm_rise = (st_reg.zm_sync[2:1] == 2'b11) && !st_reg.zm_lvl;
      // away travel is opposite to the reference direction
      lim_away = st_reg.drv_dir ? st_reg.lf_lvl : st_reg.lr_lvl;
      calib_start = start_i && (mode_i == `AHS_MODE_CALIB);
      // reading to coordinate, relative to the bound pair
      pos_now = st_reg.bind_coord + (enc_pos_i - st_reg.bind_enc);
   end

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      // synchroniser shifts; stage 0 feeds only stage 1
      st_next.pc_sync = {st_reg.pc_sync[1:0], prox_precontact_i};
      st_next.zm_sync = {st_reg.zm_sync[1:0], zero_marker_i};
      st_next.lf_sync = {st_reg.lf_sync[1:0], limit_fwd_i};
      st_next.lr_sync = {st_reg.lr_sync[1:0], limit_rev_i};
      if (st_reg.pc_sync[2] == st_reg.pc_sync[1]) begin
         st_next.pc_lvl = st_reg.pc_sync[2];
      end
      if (st_reg.zm_sync[2] == st_reg.zm_sync[1]) begin
         st_next.zm_lvl = st_reg.zm_sync[2];
      end
      if (st_reg.lf_sync[2] == st_reg.lf_sync[1]) begin
         st_next.lf_lvl = st_reg.lf_sync[2];
      end
      if (st_reg.lr_sync[2] == st_reg.lr_sync[1]) begin
         st_next.lr_lvl = st_reg.lr_sync[2];
      end
      st_next.mderr = 1'b0;
      // modes needing a home point are refused without one
      st_next.blk = start_i && !st_reg.home && ((mode_i == `AHS_MODE_INC_ABS) ||
         (mode_i == `AHS_MODE_AUTO) || (mode_i == `AHS_MODE_AUTO_SINGLE) ||
         (mode_i == `AHS_MODE_TEACH));
      // backup loss or removal forgets an absolute home
      if (ABS_ENC && (!backup_ok_i || module_removed_i)) begin
         st_next.home = 1'b0;
      end
      // first traverse after set ends the backlash skip
      if (move_done_i) begin
         st_next.bl_skip = 1'b0;
      end
      case (st_reg.phase)
         AHS_IDLE: begin
            if (calib_start && !md_valid_i) begin
               st_next.mderr = 1'b1;
            end else if (calib_start) begin
               st_next.home = 1'b0;
               if (set_only_i || ABS_ENC) begin
                  // no motion; precontact and marker ignored
                  st_next.bind_enc = enc_pos_i;
                  st_next.bind_coord = ref_coord_i;
                  st_next.home = 1'b1;
                  st_next.bl_skip = backlash_nz_i;
               end else if (st_reg.pc_lvl) begin
                  st_next.drv_en = 1'b1;
                  st_next.drv_dir = ref_dir_i;
                  st_next.spd = `AHS_SPEED_REF2;
                  st_next.phase = AHS_TOWARD;
               end else if (ref_dir_i ? st_reg.lr_lvl : st_reg.lf_lvl) begin
                  st_next.drv_en = 1'b1;
                  st_next.drv_dir = ref_dir_i;
                  st_next.spd = `AHS_SPEED_REF1;
                  st_next.phase = AHS_TOWARD;
               end else begin
                  st_next.drv_en = 1'b1;
                  st_next.drv_dir = !ref_dir_i;
                  st_next.spd = `AHS_SPEED_REF1;
                  st_next.seen_pc = 1'b0;
                  st_next.phase = AHS_AWAY;
               end
            end
         end
         AHS_AWAY: begin
            // reverse at the limit, or at precontact end
            if (pc_rise) begin
               st_next.seen_pc = 1'b1;
            end
            if (lim_away || (st_reg.seen_pc && pc_fall)) begin
               st_next.drv_dir = ref_dir_i;
               st_next.phase = AHS_TOWARD;
            end
         end
         AHS_TOWARD: begin
            if (pc_rise) begin
               st_next.spd = `AHS_SPEED_REF2;
            end
            if (pc_fall) begin
               st_next.phase = AHS_ARMED;
            end
         end
         AHS_ARMED: begin
            if (zm_rise) begin
               st_next.bind_enc = enc_pos_i;
               st_next.bind_coord = ref_coord_i;
               st_next.home = 1'b1;
               st_next.bl_skip = backlash_nz_i;
               st_next.drv_en = 1'b0;
               st_next.spd = `AHS_SPEED_STOP;
               st_next.phase = AHS_BRAKE;
            end
         end
         AHS_BRAKE: begin
            if (drive_at_rest_i) begin
               st_next.phase = AHS_IDLE;
            end
         end
         default: begin
            st_next.phase = AHS_IDLE;
         end
      endcase
      // abort of a run: stop and leave no home point
      if (stop_i && (st_reg.phase != AHS_IDLE) && (st_reg.phase != AHS_BRAKE)) begin
         st_next.home = 1'b0;
         st_next.drv_en = 1'b0;
         st_next.spd = `AHS_SPEED_STOP;
         st_next.phase = AHS_IDLE;
      end
      // actual value carries the offsets
      st_next.act = pos_now + offset_i;
   end

   // ------------------------------------------------------------
   // state register; reset is power-on
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg <= '0; // home cleared at power-on
         st_reg.phase <= AHS_IDLE;
         st_reg.bind_enc <= `AHS_ENC_RESET;
         st_reg.bind_coord <= `AHS_POS_RESET;
         st_reg.act <= `AHS_POS_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // outputs straight from flops
   // ------------------------------------------------------------
   assign drive_en_o = st_reg.drv_en;
   assign drive_dir_o = st_reg.drv_dir;
   assign speed_sel_o = st_reg.spd;
   assign home_set_o = st_reg.home;
   assign soft_limit_en_o = st_reg.home;
   assign mode_block_o = st_reg.blk;
   assign md_error_o = st_reg.mderr;
   assign backlash_skip_o = st_reg.bl_skip;
   assign actual_pos_o = st_reg.act;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_set_home;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (st_reg.phase == AHS_IDLE && calib_start && md_valid_i && set_only_i && !stop_i) |=> home_set_o;
   endproperty
   a_set_home: assert property (p_set_home) else $error("set reference did not set home");

   property p_no_data;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (calib_start && !md_valid_i && st_reg.phase == AHS_IDLE) |=> md_error_o && !drive_en_o;
   endproperty
   a_no_data: assert property (p_no_data) else $error("start accepted without machine data");

   property p_block;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (start_i && mode_i == `AHS_MODE_AUTO && !home_set_o) |=> mode_block_o;
   endproperty
   a_block: assert property (p_block) else $error("automatic mode not refused");

   property p_clear;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (st_reg.phase == AHS_IDLE && calib_start && md_valid_i && !set_only_i && !ABS_ENC) |=> !home_set_o;
   endproperty
   a_clear: assert property (p_clear) else $error("home not cleared at run start");

   property p_away;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (st_reg.phase == AHS_AWAY) |-> drive_dir_o != ref_dir_i || $past(st_reg.phase) != AHS_IDLE;
   endproperty
   a_away: assert property (p_away) else $error("away leg in wrong direction");

   property p_speed2;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (st_reg.phase == AHS_TOWARD && pc_rise && !stop_i) |=> speed_sel_o == `AHS_SPEED_REF2;
   endproperty
   a_speed2: assert property (p_speed2) else $error("speed 2 not selected");

   property p_arm;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (st_reg.phase == AHS_TOWARD && zm_rise && !pc_fall) |=> !home_set_o;
   endproperty
   a_arm: assert property (p_arm) else $error("marker taken before arming");

   property p_marker;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (st_reg.phase == AHS_ARMED && zm_rise && !stop_i) |=> home_set_o && !drive_en_o ##1
         actual_pos_o == $past(ref_coord_i, 2) + $past(offset_i) + ($past(enc_pos_i) - $past(enc_pos_i, 2));
   endproperty
   a_marker: assert property (p_marker) else $error("marker did not load coordinate");

   property p_abort;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (stop_i && (st_reg.phase == AHS_AWAY || st_reg.phase == AHS_TOWARD || st_reg.phase == AHS_ARMED))
         |=> !home_set_o && !drive_en_o;
   endproperty
   a_abort: assert property (p_abort) else $error("abort left a home point");

   // special starts: the filtered pin levels decide the first leg
   property p_start_pc;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (st_reg.phase == AHS_IDLE && calib_start && md_valid_i && !set_only_i && !ABS_ENC && st_reg.pc_lvl)
         |=> drive_en_o && drive_dir_o == $past(ref_dir_i) && speed_sel_o == `AHS_SPEED_REF2;
   endproperty
   a_start_pc: assert property (p_start_pc) else $error("start on precontact not toward at speed 2");

   property p_start_lim;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (st_reg.phase == AHS_IDLE && calib_start && md_valid_i && !set_only_i && !ABS_ENC && !st_reg.pc_lvl &&
         (ref_dir_i ? st_reg.lr_lvl : st_reg.lf_lvl)) |=> drive_en_o && drive_dir_o == $past(ref_dir_i);
   endproperty
   a_start_lim: assert property (p_start_lim) else $error("start on limit not toward reference");

   // leaving the precontact on the away leg turns the axis round
   property p_rev_pc;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (st_reg.phase == AHS_AWAY && st_reg.seen_pc && pc_fall && !stop_i)
         |=> drive_dir_o == $past(ref_dir_i) && st_reg.phase == AHS_TOWARD;
   endproperty
   a_rev_pc: assert property (p_rev_pc) else $error("no reversal at precontact end");

   property p_backlash;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (st_reg.phase == AHS_IDLE && calib_start && md_valid_i && set_only_i) |=> backlash_skip_o == $past(backlash_nz_i);
   endproperty
   a_backlash: assert property (p_backlash) else $error("backlash skip not armed by set");

   c_run: cover property (@(posedge ref_clk_i) st_reg.phase == AHS_ARMED ##[1:1000] home_set_o);
   c_set: cover property (@(posedge ref_clk_i) calib_start && set_only_i ##1 home_set_o);
   c_rev_pc: cover property (@(posedge ref_clk_i) st_reg.phase == AHS_AWAY && st_reg.seen_pc && pc_fall);
   c_start_pc: cover property (@(posedge ref_clk_i) calib_start && st_reg.pc_lvl ##1 speed_sel_o == `AHS_SPEED_REF2);
   c_abort: cover property (@(posedge ref_clk_i) stop_i && st_reg.phase == AHS_AWAY);
endmodule : ahs_sequencer

// ===== tb/ahs_axis_model.sv
// behavioural axis: encoder, precontact cam, zero marker and hardware limits
`timescale 1ns/100ps
`include "ahs_consts.svh"
module ahs_axis_model #(
   parameter int PRE_LO = 400, // precontact cam start
   parameter int PRE_HI = 460, // precontact cam end
   parameter int LIM_LO = 0, // reverse limit position
   parameter int LIM_HI = 1000 // forward limit position
) (
   input wire logic ref_clk_i, // module clock
   input wire logic drive_en_i, // drive moving
   input wire logic drive_dir_i, // 1 forward
   input wire logic [1:0] speed_sel_i, // speed choice
   output logic prox_precontact_o, // cam contact
   output logic zero_marker_o, // encoder zero pulse
   output logic limit_fwd_o, // forward limit
   output logic limit_rev_o, // reverse limit
   output logic drive_at_rest_o, // standstill
   output logic [`AHS_POS_W-1:0] enc_pos_o // encoder count
);
   // -----------------------------------------
   // motion
   // -----------------------------------------
   int pos = 300; // axis position, also placed by the bench
   int rest_cnt = 0; // cycles since the drive stopped
   // step by the selected speed; no inertia, so braking is short
   always @(posedge ref_clk_i) begin
      if (drive_en_i && speed_sel_i != `AHS_SPEED_STOP) begin
         pos <= drive_dir_i ? pos + int'(speed_sel_i) : pos - int'(speed_sel_i);
         rest_cnt <= 0;
      end else if (rest_cnt < 8) begin
         rest_cnt <= rest_cnt + 1;
      end
   end
   // -----------------------------------------
   // pins
   // -----------------------------------------
   // normally open: high only on the cam, falls before the marker going forward
   assign prox_precontact_o = (pos >= PRE_LO) && (pos <= PRE_HI);
   // short marker window once per hundred units, rising edge is the event
   assign zero_marker_o = (pos >= 0) && ((pos % 100) < 4);
   assign limit_rev_o = (pos <= LIM_LO);
   assign limit_fwd_o = (pos >= LIM_HI);
   assign drive_at_rest_o = !drive_en_i && (rest_cnt >= 4);
   assign enc_pos_o = pos;
endmodule : ahs_axis_model

// ===== tb/ahs_sequencer_test.sv
// self-checking bench of the axis homing sequencer
`timescale 1ns/100ps
`include "ahs_consts.svh"
module ahs_sequencer_test;
   logic ref_clk_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0, stop_i = 1'b0, set_only_i = 1'b0;
   logic md_valid_i = 1'b1, ref_dir_i = 1'b1, backlash_nz_i = 1'b0, move_done_i = 1'b0;
   logic backup_ok_i = 1'b1, module_removed_i = 1'b0; // incremental variant: unused levels
   logic [`AHS_MODE_W-1:0] mode_i = '0;
   logic [31:0] ref_coord_i = '0, offset_i = '0, enc_pos_i, actual_pos_o, diff;
   logic prox_precontact_i, zero_marker_i, limit_fwd_i, limit_rev_i, drive_at_rest_i;
   logic drive_en_o, drive_dir_o, home_set_o, soft_limit_en_o, mode_block_o, md_error_o, backlash_skip_o;
   logic [1:0] speed_sel_o;
   int bad_count = 0, n_compared = 0, cycles = 0;
   int exp_home = 0; // reference model: home point present
   int fl, fs, lo, p0; // positions seen at flip, speed-up, lowest, start
   logic [31:0] seed = 32'h0000_6b71;
   logic pulse_blk, pulse_err; // pulses caught after a start
   logic [4:0] blocked [4] = '{`AHS_MODE_INC_ABS, `AHS_MODE_AUTO, `AHS_MODE_AUTO_SINGLE, `AHS_MODE_TEACH};
   // -----------------------------------------
   // clock, timeout, instances
   // -----------------------------------------
   always #5 ref_clk_i = ~ref_clk_i;
   // a hang counts as a mismatch
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_sim();
      end
   end
   ahs_sequencer #(.POS_W(32), .ABS_ENC(1'b0)) ahs_sequencer_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .mode_i(mode_i), .start_i(start_i), .stop_i(stop_i), .set_only_i(set_only_i), .md_valid_i(md_valid_i),
      .ref_dir_i(ref_dir_i), .ref_coord_i(ref_coord_i), .offset_i(offset_i), .enc_pos_i(enc_pos_i),
      .backlash_nz_i(backlash_nz_i), .move_done_i(move_done_i), .backup_ok_i(backup_ok_i),
      .module_removed_i(module_removed_i), .prox_precontact_i(prox_precontact_i),
      .zero_marker_i(zero_marker_i), .limit_fwd_i(limit_fwd_i), .limit_rev_i(limit_rev_i),
      .drive_at_rest_i(drive_at_rest_i), .drive_en_o(drive_en_o), .drive_dir_o(drive_dir_o),
      .speed_sel_o(speed_sel_o), .home_set_o(home_set_o), .soft_limit_en_o(soft_limit_en_o),
      .mode_block_o(mode_block_o), .md_error_o(md_error_o), .backlash_skip_o(backlash_skip_o),
      .actual_pos_o(actual_pos_o));
   ahs_axis_model ahs_axis_model_inst (.ref_clk_i(ref_clk_i), .drive_en_i(drive_en_o),
      .drive_dir_i(drive_dir_o), .speed_sel_i(speed_sel_o), .prox_precontact_o(prox_precontact_i),
      .zero_marker_o(zero_marker_i), .limit_fwd_o(limit_fwd_i), .limit_rev_o(limit_rev_i),
      .drive_at_rest_o(drive_at_rest_i), .enc_pos_o(enc_pos_i));
   // -----------------------------------------
   // helpers
   // -----------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // home flag and soft limit enable both follow the model
   task automatic check_home();
      check(home_set_o, exp_home);
      check(soft_limit_en_o, exp_home);
   endtask : check_home
   // park the axis, fresh random coordinate and offset
   task automatic place(input int p);
      @(posedge ref_clk_i);
      ahs_axis_model_inst.pos <= p;
      seed = xorshift(seed);
      ref_coord_i <= seed;
      seed = xorshift(seed);
      offset_i <= seed;
      repeat (8) @(posedge ref_clk_i);
      p0 = p;
   endtask : place
   // one start pulse, catching the one-cycle answers
   task automatic start_op(input logic [4:0] m, input logic s);
      @(posedge ref_clk_i);
      mode_i <= m;
      set_only_i <= s;
      start_i <= 1'b1;
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      pulse_blk = 1'b0;
      pulse_err = 1'b0;
      repeat (3) begin
         @(negedge ref_clk_i);
         pulse_blk |= (mode_block_o === 1'b1);
         pulse_err |= (md_error_o === 1'b1);
      end
   endtask : start_op
   // follow a homing run to the home flag, then to rest
   task automatic run_watch();
      fl = -999;
      fs = -999;
      lo = 99999;
      for (int i = 0; i < 3000 && home_set_o !== 1'b1; i++) begin
         @(negedge ref_clk_i);
         if (fl == -999 && drive_dir_o === 1'b1) fl = ahs_axis_model_inst.pos;
         if (fs == -999 && speed_sel_o === `AHS_SPEED_REF2) fs = ahs_axis_model_inst.pos;
         if (ahs_axis_model_inst.pos < lo) lo = ahs_axis_model_inst.pos;
      end
      exp_home = 1;
      check(ahs_axis_model_inst.pos >= 500 && ahs_axis_model_inst.pos <= 512, 1);
      for (int i = 0; i < 50 && drive_at_rest_i !== 1'b1; i++) @(negedge ref_clk_i);
      repeat (2) @(negedge ref_clk_i);
      check_home();
      diff = actual_pos_o - ref_coord_i - offset_i;
      check(diff <= 32'd16, 1);
   endtask : run_watch
   task automatic end_sim();
      if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check_home();
      foreach (blocked[i]) begin
         start_op(blocked[i], 1'b0);
         check(pulse_blk, 1);
      end
      // missing machine data refuses calibration; levels change on a rising edge
      @(posedge ref_clk_i);
      md_valid_i <= 1'b0;
      start_op(`AHS_MODE_CALIB, 1'b1);
      check(pulse_err, 1);
      check_home();
      @(posedge ref_clk_i);
      md_valid_i <= 1'b1;
      // set without movement, backlash configured
      place(300);
      backlash_nz_i <= 1'b1;
      start_op(`AHS_MODE_CALIB, 1'b1);
      exp_home = 1;
      check_home();
      check(drive_en_o, 0);
      check(actual_pos_o, ref_coord_i + offset_i);
      check(ahs_axis_model_inst.pos, p0);
      check(backlash_skip_o, 1);
      @(posedge ref_clk_i);
      move_done_i <= 1'b1;
      @(posedge ref_clk_i);
      move_done_i <= 1'b0;
      repeat (2) @(negedge ref_clk_i);
      check(backlash_skip_o, 0);
      start_op(`AHS_MODE_INC_ABS, 1'b0);
      check(pulse_blk, 0);
      // abort in mid-run drops the home point
      place(300);
      start_op(`AHS_MODE_CALIB, 1'b0);
      exp_home = 0;
      check_home();
      repeat (40) @(posedge ref_clk_i);
      stop_i <= 1'b1;
      @(posedge ref_clk_i);
      stop_i <= 1'b0;
      repeat (6) @(negedge ref_clk_i);
      check_home();
      check(drive_en_o, 0);
      // full run: away, limit, precontact, marker
      place(300);
      start_op(`AHS_MODE_CALIB, 1'b0);
      check({drive_en_o, drive_dir_o, speed_sel_o}, {2'b10, `AHS_SPEED_REF1});
      run_watch();
      check(fl <= 0 && fl >= -6, 1);
      check(fs >= 400 && fs <= 410, 1);
      // precontact met while moving away
      place(470);
      start_op(`AHS_MODE_CALIB, 1'b0);
      exp_home = 0;
      check_home();
      run_watch();
      check(fl >= 390 && fl < 400 && lo > 0, 1);
      // start on the precontact
      place(430);
      start_op(`AHS_MODE_CALIB, 1'b0);
      check({drive_en_o, drive_dir_o, speed_sel_o}, {2'b11, `AHS_SPEED_REF2});
      run_watch();
      // start on the reversing limit
      place(-2);
      start_op(`AHS_MODE_CALIB, 1'b0);
      check({drive_en_o, drive_dir_o, speed_sel_o}, {2'b11, `AHS_SPEED_REF1});
      run_watch();
      end_sim();
   end
endmodule : ahs_sequencer_test
